/* File: srs_pkg.sv */
package srs_pkg;

	// ***********************************************************
	// timing
	// ***********************************************************
	localparam int CLK_PERIOD_NS = 100;
	localparam int RST_HOLD_NS   = 1000;
	localparam int RST_HOLD_CYC  = (RST_HOLD_NS + CLK_PERIOD_NS - 1)
	                               / CLK_PERIOD_NS;
	localparam int SS_STEP_NS    = 1600;
	localparam int SS_STEP_CYC   = SS_STEP_NS / CLK_PERIOD_NS;
	localparam logic [7:0] RST_HOLD_LD = 8'(RST_HOLD_CYC - 1);
	localparam logic [7:0] SS_STEP_LD  = 8'(SS_STEP_CYC - 1);

	// ***********************************************************
	// sizes
	// ***********************************************************
	localparam int GPIO_N  = 83;
	localparam int GPIO_W  = 96;
	localparam int ADDR_W  = 6;
	localparam int EXT_N   = 4;
	localparam logic [GPIO_W-1:0] GPIO_MASK = {{13{1'b0}}, {83{1'b1}}};

	// ***********************************************************
	// register map, byte addresses
	// ***********************************************************
	localparam logic [ADDR_W-1:0] REG_CTRL     = 6'h00;
	localparam logic [ADDR_W-1:0] REG_EXT_RST  = 6'h04;
	localparam logic [ADDR_W-1:0] REG_STATUS   = 6'h08;
	localparam logic [ADDR_W-1:0] REG_CAUSE    = 6'h0C;
	localparam logic [ADDR_W-1:0] REG_GPIO_SEL = 6'h10;
	localparam logic [ADDR_W-1:0] REG_GPIO_DIR = 6'h14;
	localparam logic [ADDR_W-1:0] REG_GPIO_OUT = 6'h18;
	localparam logic [ADDR_W-1:0] REG_GPIO_OD  = 6'h1C;
	localparam logic [ADDR_W-1:0] REG_GPIO_ALT = 6'h20;
	localparam logic [ADDR_W-1:0] REG_GPIO_AK  = 6'h24;
	localparam logic [ADDR_W-1:0] REG_GPIO_IN  = 6'h28;

	// control bits
	localparam int CTRL_PLL_EN  = 0;
	localparam int CTRL_DIV_REL = 1;
	localparam int CTRL_FE_CLK  = 2;
	localparam int CTRL_IO_EN   = 3;
	localparam int CTRL_LOW_PWR = 4;
	localparam int CTRL_SS_LSB  = 5;
	// status bits
	localparam int STAT_MLOCK   = 0;
	localparam int STAT_LLOCK   = 1;
	localparam int STAT_CPU_RUN = 2;
	localparam int STAT_LCLK    = 3;
	// cause bits, write one to clear
	localparam logic [3:0] CAUSE_POR  = 4'h1;
	localparam logic [3:0] CAUSE_PG   = 4'h2;
	localparam logic [3:0] CAUSE_WDT  = 4'h4;
	localparam logic [3:0] CAUSE_LAMP = 4'h8;

	// spread depth codes and triangle peaks, unit 1/64 percent
	localparam logic [1:0] SS_OFF  = 2'h0;
	localparam logic [1:0] SS_HALF = 2'h1;
	localparam logic [1:0] SS_FULL = 2'h2;
	localparam logic [7:0] SS_PEAK_HALF = 8'h20;
	localparam logic [7:0] SS_PEAK_FULL = 8'h40;

	typedef enum logic [1:0] {
		ST_MPLL_START,
		ST_MPLL_WAIT,
		ST_SYS_RESET,
		ST_RUN
	} srs_fsm_e;

	typedef struct packed {
		logic              read;
		logic              write;
		logic [ADDR_W-1:0] address;
		logic [31:0]       writedata;
		logic [3:0]        byteenable;
	} srs_avs_req_s;

endpackage

/* File: srs_sequencer.sv */
`timescale 1ns/10ps
// Contract
// - power-up starts master PLL unaided, normal mode, then system reset.
// - any reset source returns the device to normal power mode.
// - every GPIO pin goes high-impedance on any system reset.
// - master PLL keeps running; only power-up reset restarts it.
// - only processor domain resets release; others wait for software.
// - processor clocks come out of reset at full rate.
// - front-end clocks stay disabled after reset until software enables.
// - link PLL powered down after reset, derived clocks off, resets held.
// - link output drivers powered down after reset, outputs tri-stated.
// - external reset outputs held until processor releases them.
// - processor boots from external flash after reset release.
// - link PLL enabled while dividers held in reset until released.
// - link PLL lock is visible to firmware before rates are set.
// - divider release enables link clocks; external resets released last.
// - spread modulation made internally, applied only to link clock.
// - modulation profile is triangular only.
// - spread depth selectable: zero, half and one percent center.
// - 83 GPIO pins each with own direction setting.
// - each GPIO output push-pull or open-drain; alternate functions.
// - reset sets GPIO input; clears alternates except clock and PWM.
module srs_sequencer
	import srs_pkg::*;
(
	input  wire logic                 clk,
	input  wire logic                 nrst,
	input  wire srs_avs_req_s         avs_req,
	output logic                      avs_waitrequest,
	output logic [31:0]               avs_readdata,
	input  wire logic                 power_good_input,
	input  wire logic                 lamp_strike_in,
	input  wire logic                 watchdog_timeout,
	input  wire logic                 master_pll_lock,
	input  wire logic                 link_pll_lock,
	input  wire logic [GPIO_N-1:0]    gpio_in,
	output logic [GPIO_N-1:0]         gpio_out,
	output logic [GPIO_N-1:0]         gpio_oe,
	output logic [GPIO_N-1:0]         gpio_alt_en,
	output logic                      master_pll_en,
	output logic                      cpu_rst_n,
	output logic                      cpu_clk_full,
	output logic                      boot_from_flash,
	output logic                      fe_clk_en,
	output logic                      display_link_pll_pd,
	output logic                      link_div_rst_n,
	output logic                      link_clk_en,
	output logic                      link_io_pd,
	output logic                      link_io_oe,
	output logic [EXT_N-1:0]          ext_rst_n,
	output logic                      low_power,
	output logic [7:0]                ss_offset
);

	// ***********************************************************
	// state
	// ***********************************************************
	typedef struct packed {
		srs_fsm_e            fsm;
		logic [7:0]          hold_cnt;
		logic                pg_s1;
		logic                pg_s2;
		logic                lamp_s1;
		logic                lamp_s2;
		logic                mlock_s1;
		logic                mlock_s2;
		logic                llock_s1;
		logic                llock_s2;
		logic [GPIO_N-1:0]   gin_s1;
		logic [GPIO_N-1:0]   gin_s2;
		logic                wait_q;
		logic [31:0]         rdata;
		logic                pll_en;
		logic                div_rel;
		logic                fe_clk;
		logic                io_en;
		logic                low_pwr;
		logic [1:0]          ss_depth;
		logic [EXT_N-1:0]    ext_rel;
		logic [3:0]          cause;
		logic [1:0]          gsel;
		logic [GPIO_W-1:0]   gdir;
		logic [GPIO_W-1:0]   gout;
		logic [GPIO_W-1:0]   god;
		logic [GPIO_W-1:0]   galt;
		logic [GPIO_W-1:0]   galtk;
		logic [7:0]          ss_cnt;
		logic [7:0]          ss_tri;
		logic                ss_up;
		logic                mpll_en;
		logic                cpu_rst_n;
		logic                cpu_full;
		logic                boot_flash;
		logic                fe_clk_en;
		logic                lpll_pd;
		logic                ldiv_rst_n;
		logic                lclk_en;
		logic                lio_pd;
		logic                lio_oe;
		logic [EXT_N-1:0]    ext_rst_n;
		logic                low_power;
		logic [7:0]          ss_offset;
		logic [GPIO_N-1:0]   gpio_out;
		logic [GPIO_N-1:0]   gpio_oe;
		logic [GPIO_N-1:0]   gpio_alt;
	} srs_state_s;

	srs_state_s s;
	srs_state_s next_s;

	// ***********************************************************
	// helpers
	// ***********************************************************
	function automatic logic [31:0] be_merge(input logic [31:0] old_v,
		input logic [31:0] new_v, input logic [3:0] be);
		logic [31:0] r;
		r = old_v;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				r[i*8 +: 8] = new_v[i*8 +: 8];
			end
		end
		return r;
	endfunction

	function automatic logic [31:0] get_word(input logic [GPIO_W-1:0] v,
		input logic [1:0] sel);
		logic [31:0] r;
		case (sel)
			2'h0: r = v[31:0];
			2'h1: r = v[63:32];
			2'h2: r = v[95:64];
			default: r = 32'h0000_0000;
		endcase
		return r;
	endfunction

	function automatic logic [GPIO_W-1:0] put_word(
		input logic [GPIO_W-1:0] v, input logic [1:0] sel,
		input logic [31:0] d, input logic [3:0] be);
		logic [GPIO_W-1:0] r;
		r = v;
		case (sel)
			2'h0: r[31:0]  = be_merge(v[31:0], d, be);
			2'h1: r[63:32] = be_merge(v[63:32], d, be);
			2'h2: r[95:64] = be_merge(v[95:64], d, be);
			default: r = v;
		endcase
		return r & GPIO_MASK;
	endfunction

	// ***********************************************************
	// next state
	// ***********************************************************
	logic              rst_req;
	logic              in_reset;
	logic              wr_take;
	logic              rd_take;
	logic [7:0]        peak;
	logic [GPIO_W-1:0] gin_pad;

	always_comb begin
		next_s = s;
		next_s.pg_s1    = power_good_input;
		next_s.pg_s2    = s.pg_s1;
		next_s.lamp_s1  = lamp_strike_in;
		next_s.lamp_s2  = s.lamp_s1;
		next_s.mlock_s1 = master_pll_lock;
		next_s.mlock_s2 = s.mlock_s1;
		next_s.llock_s1 = link_pll_lock;
		next_s.llock_s2 = s.llock_s1;
		next_s.gin_s1   = gpio_in;
		next_s.gin_s2   = s.gin_s1;
		gin_pad = {{(GPIO_W - GPIO_N){1'b0}}, s.gin_s2};
		rst_req = !s.pg_s2 || watchdog_timeout || s.lamp_s2;

		// sequencing
		case (s.fsm)
			ST_MPLL_START: begin
				next_s.mpll_en = 1'b1;
				next_s.fsm = ST_MPLL_WAIT;
			end
			ST_MPLL_WAIT: begin
				if (s.mlock_s2) begin
					next_s.fsm = ST_SYS_RESET;
					next_s.hold_cnt = RST_HOLD_LD;
				end
			end
			ST_SYS_RESET: begin
				if (rst_req) begin
					next_s.hold_cnt = RST_HOLD_LD;
				end else if (s.hold_cnt == 8'h00) begin
					next_s.fsm = ST_RUN;
				end else begin
					next_s.hold_cnt = s.hold_cnt - 8'h01;
				end
			end
			ST_RUN: begin
				if (rst_req) begin
					next_s.fsm = ST_SYS_RESET;
					next_s.hold_cnt = RST_HOLD_LD;
				end
			end
			default: begin
				next_s.fsm = ST_MPLL_START;
			end
		endcase
		in_reset = (s.fsm != ST_RUN) || rst_req;

		// sticky causes, set wins over clear
		if (s.wait_q == 1'b0 && avs_req.write &&
			avs_req.address == REG_CAUSE) begin
			next_s.cause = s.cause & ~avs_req.writedata[3:0];
		end
		if (!s.pg_s2) begin
			next_s.cause = next_s.cause | CAUSE_PG;
		end
		if (watchdog_timeout) begin
			next_s.cause = next_s.cause | CAUSE_WDT;
		end
		if (s.lamp_s2) begin
			next_s.cause = next_s.cause | CAUSE_LAMP;
		end

		// bus slave: one wait cycle, then complete
		next_s.wait_q = !((avs_req.read || avs_req.write) && s.wait_q);
		rd_take = avs_req.read && s.wait_q;
		wr_take = avs_req.write && !s.wait_q && !in_reset;
		if (rd_take) begin
			case (avs_req.address)
				REG_CTRL: begin
					next_s.rdata = {25'h0, s.ss_depth, s.low_pwr, s.io_en,
						s.fe_clk, s.div_rel, s.pll_en};
				end
				REG_EXT_RST: next_s.rdata = {28'h0, s.ext_rel};
				REG_STATUS: begin
					next_s.rdata = {28'h0, s.lclk_en, s.cpu_rst_n,
						s.llock_s2, s.mlock_s2};
				end
				REG_CAUSE:    next_s.rdata = {28'h0, s.cause};
				REG_GPIO_SEL: next_s.rdata = {30'h0, s.gsel};
				REG_GPIO_DIR: next_s.rdata = get_word(s.gdir, s.gsel);
				REG_GPIO_OUT: next_s.rdata = get_word(s.gout, s.gsel);
				REG_GPIO_OD:  next_s.rdata = get_word(s.god, s.gsel);
				REG_GPIO_ALT: next_s.rdata = get_word(s.galt, s.gsel);
				REG_GPIO_AK:  next_s.rdata = get_word(s.galtk, s.gsel);
				REG_GPIO_IN:  next_s.rdata = get_word(gin_pad, s.gsel);
				default:      next_s.rdata = 32'h0000_0000;
			endcase
		end
		if (wr_take) begin
			case (avs_req.address)
				REG_CTRL: begin
					if (avs_req.byteenable[0]) begin
						next_s.pll_en  = avs_req.writedata[CTRL_PLL_EN];
						next_s.div_rel = avs_req.writedata[CTRL_DIV_REL];
						next_s.fe_clk  = avs_req.writedata[CTRL_FE_CLK];
						next_s.io_en   = avs_req.writedata[CTRL_IO_EN];
						next_s.low_pwr = avs_req.writedata[CTRL_LOW_PWR];
						next_s.ss_depth =
							avs_req.writedata[CTRL_SS_LSB +: 2];
					end
				end
				REG_EXT_RST: begin
					if (avs_req.byteenable[0]) begin
						next_s.ext_rel = avs_req.writedata[EXT_N-1:0];
					end
				end
				REG_GPIO_SEL: begin
					if (avs_req.byteenable[0]) begin
						next_s.gsel = avs_req.writedata[1:0];
					end
				end
				REG_GPIO_DIR: begin
					next_s.gdir = put_word(s.gdir, s.gsel,
						avs_req.writedata, avs_req.byteenable);
				end
				REG_GPIO_OUT: begin
					next_s.gout = put_word(s.gout, s.gsel,
						avs_req.writedata, avs_req.byteenable);
				end
				REG_GPIO_OD: begin
					next_s.god = put_word(s.god, s.gsel,
						avs_req.writedata, avs_req.byteenable);
				end
				REG_GPIO_ALT: begin
					next_s.galt = put_word(s.galt, s.gsel,
						avs_req.writedata, avs_req.byteenable);
				end
				REG_GPIO_AK: begin
					next_s.galtk = put_word(s.galtk, s.gsel,
						avs_req.writedata, avs_req.byteenable);
				end
				default: begin
					next_s.gsel = s.gsel;
				end
			endcase
		end

		// defaults forced while any system reset is active
		if (in_reset) begin
			next_s.low_pwr  = 1'b0;
			next_s.pll_en   = 1'b0;
			next_s.div_rel  = 1'b0;
			next_s.fe_clk   = 1'b0;
			next_s.io_en    = 1'b0;
			next_s.ext_rel  = {EXT_N{1'b0}};
			next_s.ss_depth = SS_OFF;
			next_s.gdir     = {GPIO_W{1'b0}};
			next_s.gout     = {GPIO_W{1'b0}};
			next_s.god      = {GPIO_W{1'b0}};
			next_s.galt     = {GPIO_W{1'b0}};
			next_s.gsel     = 2'h0;
		end

		// triangular spread, link clock only
		case (next_s.ss_depth)
			SS_HALF: peak = SS_PEAK_HALF;
			SS_FULL: peak = SS_PEAK_FULL;
			default: peak = 8'h00;
		endcase
		if (!next_s.pll_en || peak == 8'h00) begin
			next_s.ss_cnt = 8'h00;
			next_s.ss_tri = peak;
			next_s.ss_up  = 1'b1;
		end else if (s.ss_cnt != SS_STEP_LD) begin
			next_s.ss_cnt = s.ss_cnt + 8'h01;
		end else begin
			next_s.ss_cnt = 8'h00;
			if (s.ss_tri > {peak[6:0], 1'b0}) begin
				next_s.ss_tri = peak;
			end else if (s.ss_up) begin
				next_s.ss_up  = (s.ss_tri + 8'h01) < {peak[6:0], 1'b0};
				next_s.ss_tri = s.ss_tri + 8'h01;
			end else begin
				next_s.ss_up  = (s.ss_tri - 8'h01) == 8'h00;
				next_s.ss_tri = s.ss_tri - 8'h01;
			end
		end
		next_s.ss_offset = next_s.ss_tri - peak;

		// registered outputs
		next_s.cpu_rst_n  = (next_s.fsm == ST_RUN);
		next_s.cpu_full   = !next_s.low_pwr;
		next_s.boot_flash = 1'b1;
		next_s.low_power  = next_s.low_pwr;
		next_s.fe_clk_en  = next_s.fe_clk;
		next_s.lpll_pd    = !next_s.pll_en;
		next_s.ldiv_rst_n = next_s.pll_en && next_s.div_rel;
		next_s.lclk_en    = next_s.pll_en && next_s.div_rel;
		next_s.lio_pd     = !next_s.io_en;
		next_s.lio_oe     = next_s.io_en;
		next_s.ext_rst_n  = next_s.ext_rel;
		next_s.gpio_oe    = next_s.gdir[GPIO_N-1:0] &
			~(next_s.god[GPIO_N-1:0] & next_s.gout[GPIO_N-1:0]);
		next_s.gpio_out   = next_s.gout[GPIO_N-1:0] &
			~next_s.god[GPIO_N-1:0];
		next_s.gpio_alt   = next_s.galt[GPIO_N-1:0] |
			next_s.galtk[GPIO_N-1:0];
	end

	// ***********************************************************
	// registers
	// ***********************************************************
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			s <= '0;
			s.fsm <= ST_MPLL_START;
			s.wait_q <= 1'b1;
			// power good idles high: no false loss after reset
			s.pg_s1 <= 1'b1;
			s.pg_s2 <= 1'b1;
			s.cause <= CAUSE_POR;
			s.lpll_pd <= 1'b1;
			s.lio_pd <= 1'b1;
			s.cpu_full <= 1'b1;
		end else begin
			s <= next_s;
		end
	end

	assign avs_waitrequest     = s.wait_q;
	assign avs_readdata        = s.rdata;
	assign gpio_out            = s.gpio_out;
	assign gpio_oe             = s.gpio_oe;
	assign gpio_alt_en         = s.gpio_alt;
	assign master_pll_en       = s.mpll_en;
	assign cpu_rst_n           = s.cpu_rst_n;
	assign cpu_clk_full        = s.cpu_full;
	assign boot_from_flash     = s.boot_flash;
	assign fe_clk_en           = s.fe_clk_en;
	assign display_link_pll_pd = s.lpll_pd;
	assign link_div_rst_n      = s.ldiv_rst_n;
	assign link_clk_en         = s.lclk_en;
	assign link_io_pd          = s.lio_pd;
	assign link_io_oe          = s.lio_oe;
	assign ext_rst_n           = s.ext_rst_n;
	assign low_power           = s.low_power;
	assign ss_offset           = s.ss_offset;

	// ***********************************************************
	// checks
	// ***********************************************************
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!nrst);

	mpll_keep_a: assert property (
		master_pll_en |=> master_pll_en
	) else $error("master pll dropped without power-up");

	por_start_a: assert property (
		(s.fsm == ST_MPLL_WAIT) |-> master_pll_en && !cpu_rst_n
	) else $error("master pll not started before release");

	cpu_rel_a: assert property (
		(s.fsm == ST_SYS_RESET && s.hold_cnt == 8'h00 && !rst_req)
		|=> cpu_rst_n && ext_rst_n == '0 && !link_clk_en
	) else $error("processor release wrong");

	gpio_tri_a: assert property (
		rst_req |=> gpio_oe == '0 ##1 gpio_oe == '0
	) else $error("gpio driven during reset");

	normal_mode_a: assert property (
		rst_req |=> !low_power && cpu_clk_full
	) else $error("not normal power after reset");

	fe_off_a: assert property (
		!cpu_rst_n |-> !fe_clk_en
	) else $error("front-end clock on in reset");

	link_pd_a: assert property (
		display_link_pll_pd |-> !link_clk_en && !link_div_rst_n
	) else $error("link clock alive with pll down");

	link_io_a: assert property (
		link_io_pd |-> !link_io_oe
	) else $error("link drivers on while powered down");

	ext_rst_a: assert property (
		$fell(cpu_rst_n) |-> ext_rst_n == '0
	) else $error("external reset released in reset");

	div_hold_a: assert property (
		$rose(link_div_rst_n) |-> !display_link_pll_pd && cpu_rst_n
	) else $error("divider released without pll");

	ss_zero_a: assert property (
		s.ss_depth == SS_OFF |-> ss_offset == 8'h00
	) else $error("spread with depth zero");

	ss_bound_a: assert property (
		$signed(ss_offset) <= $signed(SS_PEAK_FULL) &&
		$signed(ss_offset) >= -$signed(SS_PEAK_FULL)
	) else $error("spread beyond full depth");

	bus_wait_a: assert property (
		(avs_req.read || avs_req.write) && avs_waitrequest
		|=> !avs_waitrequest
	) else $error("bus answer late");

endmodule

/* File: srs_testbench.sv */
`timescale 1ns/10ps
module testbench;
	import srs_pkg::*;
	logic                clk = 1'b0;
	logic                nrst = 1'b0;
	srs_avs_req_s        avs_req = '0;
	logic                avs_waitrequest;
	logic [31:0]         avs_readdata;
	logic                power_good_input = 1'b1;
	logic                lamp_strike_in = 1'b0;
	logic                watchdog_timeout = 1'b0;
	logic                master_pll_lock = 1'b0;
	logic                link_pll_lock = 1'b0;
	logic [GPIO_N-1:0]   gpio_in = '0;
	logic [GPIO_N-1:0]   gpio_out, gpio_oe, gpio_alt_en;
	logic                master_pll_en, cpu_rst_n, cpu_clk_full;
	logic                boot_from_flash, fe_clk_en, display_link_pll_pd;
	logic                link_div_rst_n, link_clk_en, link_io_pd;
	logic                link_io_oe, low_power;
	logic [EXT_N-1:0]    ext_rst_n;
	logic [7:0]          ss_offset;
	int                  err_total = 0;
	int                  cmp_count = 0;
	logic [31:0]         rs = 32'h32;
	// ***********************************************************
	// reference model state
	// ***********************************************************
	logic [6:0]          m_ctrl = '0;
	logic [3:0]          m_ext = '0;
	int                  m_sel = 0;
	logic [GPIO_W-1:0]   m_dir = '0, m_out = '0, m_od = '0;
	logic [GPIO_W-1:0]   m_alt = '0, m_keep = '0;
	int                  peaks[4] = '{0, 32, 64, 0};

	srs_sequencer dut (
		.clk(clk), .nrst(nrst), .avs_req(avs_req),
		.avs_waitrequest(avs_waitrequest), .avs_readdata(avs_readdata),
		.power_good_input(power_good_input),
		.lamp_strike_in(lamp_strike_in),
		.watchdog_timeout(watchdog_timeout),
		.master_pll_lock(master_pll_lock), .link_pll_lock(link_pll_lock),
		.gpio_in(gpio_in), .gpio_out(gpio_out), .gpio_oe(gpio_oe),
		.gpio_alt_en(gpio_alt_en), .master_pll_en(master_pll_en),
		.cpu_rst_n(cpu_rst_n), .cpu_clk_full(cpu_clk_full),
		.boot_from_flash(boot_from_flash), .fe_clk_en(fe_clk_en),
		.display_link_pll_pd(display_link_pll_pd),
		.link_div_rst_n(link_div_rst_n), .link_clk_en(link_clk_en),
		.link_io_pd(link_io_pd), .link_io_oe(link_io_oe),
		.ext_rst_n(ext_rst_n), .low_power(low_power),
		.ss_offset(ss_offset)
	);

	always #50 clk = ~clk;

	// ***********************************************************
	// helpers
	// ***********************************************************
	function automatic logic [31:0] rnd();
		rs = rs ^ (rs << 13);
		rs = rs ^ (rs >> 17);
		rs = rs ^ (rs << 5);
		return rs;
	endfunction

	function automatic logic [GPIO_W-1:0] put(logic [GPIO_W-1:0] v,
	                                          logic [31:0] d);
		if (m_sel < 3)
			v[m_sel*32 +: 32] = d;
		return v & GPIO_MASK;
	endfunction

	task automatic give_verdict();
		if (err_total == 0 && cmp_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	task automatic chk(logic [95:0] got, logic [95:0] exp, string m);
		cmp_count++;
		if (got !== exp) begin
			$display("MISMATCH %0t %s got %h exp %h", $time, m, got, exp);
			err_total++;
		end
	endtask

	task automatic bus(logic wr, logic [ADDR_W-1:0] a, logic [31:0] d,
	                   output logic [31:0] q);
		int n;
		n = 0;
		@(posedge clk);
		avs_req <= '{read: !wr, write: wr, address: a, writedata: d,
		             byteenable: 4'hF};
		do begin
			@(posedge clk);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 100);
		if (avs_waitrequest !== 1'b0) begin
			$display("MISMATCH %0t bus timeout", $time);
			err_total++;
		end
		q = avs_readdata;
		avs_req <= '0;
	endtask

	task automatic wreg(logic [ADDR_W-1:0] a, logic [31:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
		case (a)
			REG_CTRL:     m_ctrl = d[6:0];
			REG_EXT_RST:  m_ext = d[3:0];
			REG_GPIO_SEL: m_sel = int'(d[1:0]);
			REG_GPIO_DIR: m_dir = put(m_dir, d);
			REG_GPIO_OUT: m_out = put(m_out, d);
			REG_GPIO_OD:  m_od = put(m_od, d);
			REG_GPIO_ALT: m_alt = put(m_alt, d);
			REG_GPIO_AK:  m_keep = put(m_keep, d);
			default: ;
		endcase
	endtask

	task automatic rreg(logic [ADDR_W-1:0] a, logic [31:0] e, string m);
		logic [31:0] q;
		bus(1'b0, a, 32'h0, q);
		chk(96'(q), 96'(e), m);
	endtask

	task automatic check_outs(logic cpu);
		logic [6:0] c;
		@(negedge clk);
		c = m_ctrl;
		chk(96'({fe_clk_en, display_link_pll_pd, link_div_rst_n,
		         link_clk_en, link_io_pd, link_io_oe, low_power,
		         cpu_clk_full, ext_rst_n, master_pll_en,
		         boot_from_flash, cpu_rst_n}),
		    96'({c[2], !c[0], c[0] & c[1], c[0] & c[1], !c[3], c[3],
		         c[4], !c[4], m_ext, 1'b1, 1'b1, cpu}), "controls");
		chk(96'(gpio_oe), m_dir & ~(m_od & m_out), "gpio_oe");
		chk(96'(gpio_out) & m_dir, m_out & ~m_od & m_dir, "gpio_out");
		chk(96'(gpio_alt_en), m_alt | m_keep, "gpio_alt_en");
	endtask

	task automatic wait_run();
		int n;
		n = 0;
		while (cpu_rst_n !== 1'b1 && n < 2000) begin
			@(negedge clk);
			n++;
		end
		chk(96'(n >= RST_HOLD_CYC && n <= RST_HOLD_CYC + 8), 96'(1),
		    "reset hold length");
	endtask

	task automatic ss_run(logic [6:0] c, int pk);
		int cur, prev, mx, mn, gap, bad;
		wreg(REG_CTRL, 32'(c));
		@(negedge clk);
		prev = int'($signed(ss_offset));
		mx = prev;
		mn = prev;
		gap = -1;
		bad = 0;
		repeat (4200) begin
			@(negedge clk);
			cur = int'($signed(ss_offset));
			if (gap >= 0)
				gap++;
			if (cur != prev) begin
				if (cur - prev != 1 && prev - cur != 1)
					bad++;
				if (gap > 0 && gap != SS_STEP_CYC)
					bad++;
				gap = 0;
			end
			mx = (cur > mx) ? cur : mx;
			mn = (cur < mn) ? cur : mn;
			prev = cur;
		end
		chk(96'(bad), 96'(0), "spread step shape");
		chk(96'(mx), 96'(pk), "spread upper peak");
		chk(96'(-mn), 96'(pk), "spread lower peak");
	endtask

	// ***********************************************************
	// main sequence
	// ***********************************************************
	initial begin
		#(40000 * 100);
		err_total++;
		give_verdict();
	end

	initial begin
		logic [GPIO_W-1:0] gi;
		repeat (20) @(posedge clk);
		nrst <= 1'b1;
		repeat (30) @(negedge clk);
		check_outs(1'b0);
		@(posedge clk);
		master_pll_lock <= 1'b1;
		wait_run();
		check_outs(1'b1);
		rreg(REG_CAUSE, 32'(CAUSE_POR), "cause after power up");
		wreg(REG_CAUSE, 32'hF);
		rreg(REG_CAUSE, 32'h0, "cause cleared");
		rreg(6'h2C, 32'h0, "unmapped read");
		wreg(6'h30, rnd());
		wreg(REG_CTRL, 32'h1);
		check_outs(1'b1);
		rreg(REG_STATUS, 32'h5, "status before link lock");
		@(posedge clk);
		link_pll_lock <= 1'b1;
		repeat (4) @(negedge clk);
		rreg(REG_STATUS, 32'h7, "status link locked");
		wreg(REG_CTRL, 32'h3);
		check_outs(1'b1);
		rreg(REG_STATUS, 32'hF, "status link clocks on");
		wreg(REG_EXT_RST, rnd());
		check_outs(1'b1);
		@(posedge clk);
		gpio_in <= GPIO_N'({rnd(), rnd(), rnd()});
		for (int s = 0; s < 4; s++) begin
			wreg(REG_GPIO_SEL, 32'(s));
			wreg(REG_GPIO_DIR, rnd());
			wreg(REG_GPIO_OUT, rnd());
			wreg(REG_GPIO_OD, rnd());
			wreg(REG_GPIO_ALT, rnd());
			wreg(REG_GPIO_AK, rnd());
			check_outs(1'b1);
			gi = GPIO_W'(gpio_in);
			rreg(REG_GPIO_IN, (s < 3) ? gi[s*32 +: 32] : 32'h0,
			     "gpio input window");
		end
		ss_run(7'h40, 0);
		for (int d = 0; d < 4; d++)
			ss_run({2'(d), 5'h03}, peaks[d]);
		for (int src = 0; src < 3; src++) begin
			wreg(REG_CTRL, 32'h1F);
			wreg(REG_GPIO_SEL, 32'h0);
			wreg(REG_GPIO_DIR, rnd());
			wreg(REG_GPIO_ALT, rnd());
			wreg(REG_EXT_RST, rnd());
			check_outs(1'b1);
			@(posedge clk);
			power_good_input <= (src != 0);
			watchdog_timeout <= (src == 1);
			lamp_strike_in <= (src == 2);
			repeat (5) @(posedge clk);
			m_ctrl = '0;
			m_ext = '0;
			m_sel = 0;
			{m_dir, m_out, m_od, m_alt} = '0;
			check_outs(1'b0);
			@(posedge clk);
			power_good_input <= 1'b1;
			watchdog_timeout <= 1'b0;
			lamp_strike_in <= 1'b0;
			wait_run();
			check_outs(1'b1);
			rreg(REG_CAUSE, 32'h2 << src, "reset cause");
			wreg(REG_CAUSE, 32'hF);
		end
		give_verdict();
	end
endmodule
